// ### rtl/pvp_pkg.sv
// shared layouts, offsets and constants for the voice sample port
package pvp_pkg;

  // ---------------------------------------------------------------
  // register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsvdTop;
    logic [1:0] sampleFormat;
    logic [3:0] activeSlot;
    logic [1:0] masterClkRate;
    logic [4:0] rsvdMid;
    logic [2:0] rsvdLow;
    logic       longLengthSync;
    logic       highSpeedSourceSelect;
    logic       mute;
    logic       telecomInterfaceMode;
    logic       syncSuppress;
    logic       releaseEdgeSelect;
    logic       outputReleaseEnable;
    logic       lsbFirst;
    logic       signExtend;
    logic       rsvdBit3;
    logic       shortSync;
    logic       slaveMode;
    logic       rsvdBit0;
  } pvp_cfg_t;

  typedef struct packed {
    logic [7:0]  syncLimit;
    logic [7:0]  synthIncrement;
    logic [2:0]  rsvd;
    logic [12:0] synthTerminalCount;
  } pvp_jit_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [2:0]  audioGain;
    logic [15:0] txSample;
  } pvp_tx_t;

  typedef struct packed {
    logic [15:0] frameCount;
    logic [15:0] rxSample;
  } pvp_rx_t;

  typedef struct packed {
    logic clkOut;
    logic clkOe;
    logic syncOut;
    logic syncOe;
    logic dataOut;
    logic dataOe;
  } pvp_pins_t;

  // ---------------------------------------------------------------
  // offsets, reset values, write masks
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_CFG   = 8'h00;
  localparam logic [7:0]  OFS_JIT   = 8'h04;
  localparam logic [7:0]  OFS_TX    = 8'h08;
  localparam logic [7:0]  OFS_RX    = 8'h0c;
  localparam logic [31:0] CFG_RESET = 32'h00800000;
  localparam logic [31:0] CFG_WMASK = 32'h1fe01ff6;
  localparam logic [31:0] JIT_RESET = 32'h08080177;
  localparam logic [31:0] JIT_WMASK = 32'hffff1fff;
  localparam logic [31:0] TX_RESET  = 32'h00000000;
  localparam logic [31:0] TX_WMASK  = 32'h0007ffff;

  // ---------------------------------------------------------------
  // encodings and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] FMT_13        = 2'h0;
  localparam logic [1:0] FMT_16        = 2'h1;
  localparam logic [1:0] FMT_8_IN_16   = 2'h2;
  localparam logic [1:0] FMT_8_IN_8    = 2'h3;
  localparam logic [1:0] RATE_SEL_256K = 2'h0;
  localparam logic [1:0] RATE_SEL_128K = 2'h1;
  localparam logic [1:0] RATE_SEL_512K = 2'h2;

  localparam int SYS_CLK_HZ   = 10_000_000;
  localparam int SYS_CLK_MHZ  = 10;
  localparam int DDS_REF_MHZ  = 24;
  localparam int RATE_128K_HZ = 128_000;
  localparam int RATE_256K_HZ = 256_000;
  localparam int RATE_512K_HZ = 512_000;
  localparam int FRAME_HZ     = 8_000;

  localparam logic [5:0]  HALF_128K_LAST  = 6'(SYS_CLK_HZ / (2 * RATE_128K_HZ) - 1);
  localparam logic [5:0]  HALF_256K_LAST  = 6'(SYS_CLK_HZ / (2 * RATE_256K_HZ) - 1);
  localparam logic [5:0]  HALF_512K_LAST  = 6'(SYS_CLK_HZ / (2 * RATE_512K_HZ) - 1);
  localparam logic [10:0] FRAME_128K_LAST = 11'(RATE_128K_HZ / FRAME_HZ - 1);
  localparam logic [10:0] FRAME_256K_LAST = 11'(RATE_256K_HZ / FRAME_HZ - 1);
  localparam logic [10:0] FRAME_512K_LAST = 11'(RATE_512K_HZ / FRAME_HZ - 1);
  localparam logic [17:0] DDS_RATE_MUL    = 18'(2 * DDS_REF_MHZ);
  localparam logic [17:0] DDS_LIMIT_MUL   = 18'(SYS_CLK_MHZ);

  localparam logic [10:0] SLOT_8       = 11'h008;
  localparam logic [10:0] SLOT_16      = 11'h010;
  localparam logic [10:0] SYNC_LEN_8   = 11'h008;
  localparam logic [10:0] SYNC_LEN_16  = 11'h010;
  localparam logic [10:0] BIT_IDX_IDLE = 11'h7ff;

endpackage

// ### rtl/pvp_voice_port.sv
// serial voice sample port with apb configuration registers
`timescale 1ns/1ns
// Summary of operation
// - slave bit 0: we make clock, sync
// - long sync rises, short sync falls, at start
// - pad low bits or sign-extend into slot
// - 13-bit padding carries gain; 8-bit pads zero
// - bit order msb first or lsb first
// - release data out after active slot
// - release on falling or after rising edge
// - suppress sync output, bit clock keeps running
// - mute drives every data bit zero
// - source bit picks divider or synthesizer
// - long sync width eight or sixteen clocks
// - width choice only long sync, high-speed
// - rate field picks 128, 256, 512 kHz
// - slot field inert; first slot active
// - format field picks sample and slot size
// - config word resets to 0x00800000
// - terminal count bounds synthesizer accumulator
// - increment added by synthesizer each step
// - sync limit divides bit clock to frame
// - bit clock is rate over limit times 24MHz
// - frame rate is bit clock over limit times 8
module pvp_voice_port (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pcmClkIn,
  input  wire logic              pcmSyncIn,
  input  wire logic              pcmDataIn,
  output pvp_pkg::pvp_pins_t     pcmPins
);

  pvp_pkg::pvp_cfg_t cfg;
  pvp_pkg::pvp_jit_t jit;
  pvp_pkg::pvp_tx_t  txReg;
  pvp_pkg::pvp_rx_t  rxReg;
  logic        clkS1, clkS2, clkS3;
  logic        syncS1, syncS2, dataS1, dataS2;
  logic        master, bclk, toggleNow, riseTick, fallTick;
  logic        clkOe, syncOut, syncOe, dataOut, dataOe;
  logic [5:0]  divCnt, halfLast;
  logic [17:0] ddsAcc, ddsSum, ddsLim;
  logic        ddsWrap;
  logic [10:0] bitIdx, nextIdx, frameLast, slotLen, syncWidth, hsFrameLen;
  logic        syncPrev, frameStartDet, short8, txBit;
  logic [15:0] txWord, rxShift, rxShifted, rxFinal;
  logic [31:0] readData;
  logic        addrHit, setupPhase, accessDone;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] bitPos(input logic [10:0] idx, input logic lsb,
                                        input logic eightSlot);
    if (lsb)
      bitPos = idx[3:0];
    else if (eightSlot)
      bitPos = {1'b0, 3'h7 - idx[2:0]};
    else
      bitPos = 4'hf - idx[3:0];
  endfunction

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign addrHit    = (paddr[1:0] == 2'h0) && (paddr[7:4] == 4'h0);

  always_comb
  begin
    readData = 32'h00000000;
    case (paddr)
      pvp_pkg::OFS_CFG: readData = cfg;
      pvp_pkg::OFS_JIT: readData = jit;
      pvp_pkg::OFS_TX:  readData = txReg;
      pvp_pkg::OFS_RX:  readData = rxReg;
      default:          readData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (setupPhase)
    begin
      pready  <= 1'b1;
      pslverr <= ~addrHit;
      prdata  <= addrHit ? readData : 32'h00000000;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg   <= pvp_pkg::CFG_RESET;
      jit   <= pvp_pkg::JIT_RESET;
      txReg <= pvp_pkg::TX_RESET;
    end
    else if (accessDone && pwrite && addrHit)
    begin
      case (paddr)
        pvp_pkg::OFS_CFG: cfg   <= pwdata & pvp_pkg::CFG_WMASK;
        pvp_pkg::OFS_JIT: jit   <= pwdata & pvp_pkg::JIT_WMASK;
        pvp_pkg::OFS_TX:  txReg <= pwdata & pvp_pkg::TX_WMASK;
        default:          txReg <= txReg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {clkS1, clkS2, clkS3}  <= 3'h0;
      {syncS1, syncS2}       <= 2'h0;
      {dataS1, dataS2}       <= 2'h0;
    end
    else
    begin
      clkS1  <= pcmClkIn;
      clkS2  <= clkS1;
      clkS3  <= clkS2;
      syncS1 <= pcmSyncIn;
      syncS2 <= syncS1;
      dataS1 <= pcmDataIn;
      dataS2 <= dataS1;
    end
  end

  // ---------------------------------------------------------------
  // bit clock generation
  // ---------------------------------------------------------------
  // master when slave bit clear
  assign master = ~cfg.slaveMode;

  always_comb
  begin
    case (cfg.masterClkRate)
      pvp_pkg::RATE_SEL_128K: halfLast = pvp_pkg::HALF_128K_LAST;
      pvp_pkg::RATE_SEL_512K: halfLast = pvp_pkg::HALF_512K_LAST;
      default:                halfLast = pvp_pkg::HALF_256K_LAST;
    endcase
  end

  assign ddsSum  = ddsAcc + 18'(jit.synthIncrement) * pvp_pkg::DDS_RATE_MUL;
  assign ddsLim  = 18'(jit.synthTerminalCount) * pvp_pkg::DDS_LIMIT_MUL;
  // toggle rate from rate over limit
  assign ddsWrap = (ddsLim != 18'h00000) && (ddsSum >= ddsLim);

  assign toggleNow = master & (cfg.highSpeedSourceSelect ? ddsWrap : (divCnt >= halfLast));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      divCnt <= 6'h00;
      ddsAcc <= 18'h00000;
      bclk   <= 1'b0;
    end
    else
    begin
      bclk <= bclk ^ toggleNow;
      if (!master || ddsLim == 18'h00000)
        ddsAcc <= 18'h00000;
      else if (cfg.highSpeedSourceSelect)
        ddsAcc <= ddsWrap ? ddsSum - ddsLim : ddsSum;
      if (!master || cfg.highSpeedSourceSelect || divCnt >= halfLast)
        divCnt <= 6'h00;
      else
        divCnt <= divCnt + 6'h01;
    end
  end

  assign riseTick = master ? (toggleNow & ~bclk) : (clkS2 & ~clkS3);
  assign fallTick = master ? (toggleNow & bclk) : (~clkS2 & clkS3);

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  // slot size from format
  assign short8 = (cfg.sampleFormat == pvp_pkg::FMT_8_IN_8);
  assign slotLen = short8 ? pvp_pkg::SLOT_8 : pvp_pkg::SLOT_16;
  // width choice only long and high-speed
  assign syncWidth = (cfg.highSpeedSourceSelect && cfg.longLengthSync && !cfg.shortSync)
                   ? pvp_pkg::SYNC_LEN_16 : pvp_pkg::SYNC_LEN_8;
  // frame is sync limit times 8 clocks
  assign hsFrameLen = {(jit.syncLimit == 8'h00) ? 8'h01 : jit.syncLimit, 3'h0};

  always_comb
  begin
    if (cfg.highSpeedSourceSelect)
      frameLast = hsFrameLen - 11'h001;
    else
    begin
      case (cfg.masterClkRate)
        pvp_pkg::RATE_SEL_128K: frameLast = pvp_pkg::FRAME_128K_LAST;
        pvp_pkg::RATE_SEL_512K: frameLast = pvp_pkg::FRAME_512K_LAST;
        default:                frameLast = pvp_pkg::FRAME_256K_LAST;
      endcase
    end
  end

  assign frameStartDet = cfg.shortSync ? (syncPrev & ~syncS2) : (~syncPrev & syncS2);

  always_comb
  begin
    if (master)
      nextIdx = (bitIdx >= frameLast) ? 11'h000 : bitIdx + 11'h001;
    else if (frameStartDet)
      nextIdx = 11'h000;
    else
      nextIdx = (bitIdx == pvp_pkg::BIT_IDX_IDLE) ? bitIdx : bitIdx + 11'h001;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitIdx   <= pvp_pkg::BIT_IDX_IDLE;
      syncPrev <= 1'b0;
    end
    else if (riseTick)
    begin
      bitIdx   <= nextIdx;
      syncPrev <= syncS2;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncOut <= 1'b0;
      syncOe  <= 1'b0;
      clkOe   <= 1'b0;
    end
    else
    begin
      syncOe <= master;
      clkOe  <= master;
      if (!master || cfg.syncSuppress)
        syncOut <= 1'b0;
      else if (riseTick)
        syncOut <= cfg.shortSync ? (nextIdx == frameLast) : (nextIdx < syncWidth);
    end
  end

  // ---------------------------------------------------------------
  // transmit
  // ---------------------------------------------------------------
  // padding or sign extension
  always_comb
  begin
    case (cfg.sampleFormat)
      pvp_pkg::FMT_13:
        txWord = cfg.signExtend ? {{3{txReg.txSample[12]}}, txReg.txSample[12:0]}
                                : {txReg.txSample[12:0], txReg.audioGain};
      pvp_pkg::FMT_16:
        txWord = txReg.txSample;
      pvp_pkg::FMT_8_IN_16:
        txWord = cfg.signExtend ? {{8{txReg.txSample[7]}}, txReg.txSample[7:0]}
                                : {txReg.txSample[7:0], 8'h00};
      default:
        txWord = {8'h00, txReg.txSample[7:0]};
    endcase
  end

  assign txBit = (nextIdx < slotLen) ? txWord[bitPos(nextIdx, cfg.lsbFirst, short8)] : 1'b0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dataOut <= 1'b0;
    else if (cfg.mute)
      dataOut <= 1'b0;
    else if (riseTick)
      dataOut <= txBit;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dataOe <= 1'b0;
    else if (!cfg.outputReleaseEnable)
      dataOe <= 1'b1;
    else if (riseTick)
    begin
      if (nextIdx == 11'h000)
        dataOe <= 1'b1;
      else if (cfg.releaseEdgeSelect && nextIdx == slotLen)
        dataOe <= 1'b0;
    end
    else if (fallTick && !cfg.releaseEdgeSelect && bitIdx == slotLen - 11'h001)
      dataOe <= 1'b0;
    else if (bitIdx > slotLen)
      dataOe <= 1'b0;
  end

  assign pcmPins = {bclk, clkOe, syncOut, syncOe, dataOut, dataOe};

  // ---------------------------------------------------------------
  // receive
  // ---------------------------------------------------------------
  // receive bit order
  assign rxShifted = cfg.lsbFirst ? {dataS2, rxShift[15:1]} : {rxShift[14:0], dataS2};
  assign rxFinal   = !short8 ? rxShifted
                   : (cfg.lsbFirst ? {8'h00, rxShifted[15:8]} : {8'h00, rxShifted[7:0]});

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rxShift <= 16'h0000;
      rxReg   <= 32'h00000000;
    end
    else if (fallTick && bitIdx < slotLen)
    begin
      rxShift <= rxShifted;
      if (bitIdx == slotLen - 11'h001)
      begin
        rxReg.rxSample   <= rxFinal;
        rxReg.frameCount <= rxReg.frameCount + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle");
  a_cfg_reset: assert property ($rose(nrst) |-> cfg == pvp_pkg::CFG_RESET)
    else $error("config reset value wrong");
  a_slave_pins: assert property (cfg.slaveMode |=> !pcmPins.clkOe && !pcmPins.syncOe)
    else $error("slave still drives clock");
  a_sync_suppress: assert property (cfg.syncSuppress |=> !pcmPins.syncOut)
    else $error("sync not suppressed");
  a_mute_zero: assert property (cfg.mute |=> !pcmPins.dataOut)
    else $error("muted data not zero");
  a_drive_cont: assert property (!cfg.outputReleaseEnable |=> pcmPins.dataOe)
    else $error("data released while continuous");
  a_release_fall: assert property (cfg.outputReleaseEnable && !cfg.releaseEdgeSelect
      && fallTick && bitIdx == slotLen - 11'h001 |=> !pcmPins.dataOe)
    else $error("no release at falling edge");
  a_release_rise: assert property (cfg.outputReleaseEnable && cfg.releaseEdgeSelect
      && riseTick && nextIdx == slotLen |=> !pcmPins.dataOe)
    else $error("no release after rising edge");
  a_slot_idle: assert property (cfg.outputReleaseEnable && bitIdx > slotLen
      && !riseTick |=> !pcmPins.dataOe)
    else $error("driven in inactive slot");
  a_long_start: assert property (cfg.slaveMode && !cfg.shortSync && riseTick
      && !syncPrev && syncS2 |=> bitIdx == 11'h000)
    else $error("long sync start missed");
  a_short_start: assert property (cfg.slaveMode && cfg.shortSync && riseTick
      && syncPrev && !syncS2 |=> bitIdx == 11'h000)
    else $error("short sync start missed");
  a_sync_width: assert property (master && !cfg.shortSync
      && $fell(pcmPins.syncOut) && !$past(cfg.syncSuppress) |-> bitIdx == syncWidth)
    else $error("long sync width wrong");
  a_rate_div: assert property (master && !cfg.highSpeedSourceSelect
      && cfg.masterClkRate == pvp_pkg::RATE_SEL_256K
      && divCnt == pvp_pkg::HALF_256K_LAST |=> $changed(bclk))
    else $error("256k divider wrong");
  a_tx_bit: assert property (riseTick && !cfg.mute |=> pcmPins.dataOut == $past(txBit))
    else $error("wrong data bit sent");
  a_pad_gain: assert property (cfg.sampleFormat == pvp_pkg::FMT_13 && !cfg.signExtend
      |-> txWord[2:0] == txReg.audioGain)
    else $error("gain missing from padding");
  a_sign_ext: assert property (cfg.sampleFormat == pvp_pkg::FMT_8_IN_16
      && cfg.signExtend |-> txWord[15:8] == {8{txReg.txSample[7]}})
    else $error("sign extension wrong");

endmodule

// ### test/pvp_codec_model.sv
// partner codec model: bit clock, frame sync and serial data into the port
`timescale 1ns/1ns
module pvp_codec_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        en,
  input  wire logic        shortMode,
  input  wire logic [15:0] word,
  output logic             bclk,
  output logic             fsync,
  output logic             sdata
);
  logic [2:0] ph;
  logic [4:0] idx;
  logic [4:0] nidx;

  assign nidx = idx + 5'h01;

  // ---------------------------------------------------------------
  // bit clock of 8 system clocks, 32-bit frame
  // ---------------------------------------------------------------
  // clock supplied externally
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph    <= 3'h0;
      idx   <= 5'h1f;
      bclk  <= 1'b0;
      fsync <= 1'b0;
      sdata <= 1'b0;
    end
    else if (!en)
    begin
      // released lines fall to their pull-down level
      ph    <= 3'h0;
      idx   <= 5'h1f;
      bclk  <= 1'b0;
      fsync <= 1'b0;
      sdata <= 1'b0;
    end
    else
    begin
      ph <= ph + 3'h1;
      if (ph == 3'h3)
        bclk <= 1'b0;
      if (ph == 3'h7)
      begin
        bclk  <= 1'b1;
        idx   <= nidx;
        fsync <= shortMode ? (nidx == 5'h1f) : (nidx < 5'h08);
        sdata <= (nidx < 5'h10) ? word[4'hf - nidx[3:0]] : 1'b0;
      end
    end
  end
endmodule

// ### test/tb.sv
// self-checking bench for the voice sample port
`timescale 1ns/1ns
module tb;
  logic               clk;
  logic               nrst;
  logic [7:0]         paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               bclk;
  logic               fsync;
  logic               sdata;
  logic               slaveOn;
  logic               shortOn;
  pvp_pkg::pvp_pins_t pins;
  logic [31:0]        rdData;
  logic               rdErr;
  int                 badCount;
  int                 cmpCount;
  int                 cyc;
  logic [31:0]        txCfg [8] = '{32'h0, 32'h10, 32'h08000000, 32'h10000000,
                                    32'h10000010, 32'h18000000, 32'h08000020, 32'h08000400};
  logic [15:0]        txExp [8] = '{16'h95a5, 16'hf2b4, 16'h12b4, 16'hb400,
                                    16'hffb4, 16'h00b4, 16'h2d48, 16'h0000};

  pvp_voice_port u_dut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pcmClkIn(bclk), .pcmSyncIn(fsync),
    .pcmDataIn(sdata), .pcmPins(pins));

  pvp_codec_model u_codec (.clk(clk), .nrst(nrst), .en(slaveOn), .shortMode(shortOn),
    .word(16'hc35a), .bclk(bclk), .fsync(fsync), .sdata(sdata));

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      badCount++;
      $display("[FAIL] run length expected done seen hang");
      results();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdData = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function logic pick(input int s);
    case (s)
      0: return pins.clkOut;
      1: return pins.syncOut;
      default: return pins.dataOe;
    endcase
  endfunction

  task waitPin(input int s, input logic v);
    while (pick(s) !== v)
      @(posedge clk);
  endtask

  task rise(input int s);
    waitPin(s, 1'b0);
    waitPin(s, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    apb(pvp_pkg::OFS_CFG, 1'b0, 32'h0);
    chk("cfg reset", pvp_pkg::CFG_RESET, rdData);
    chk("master drivers", 32'h3, {pins.clkOe, pins.syncOe});
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, rdErr);
    apb(pvp_pkg::OFS_CFG, 1'b1, 32'hffffffff);
    apb(pvp_pkg::OFS_CFG, 1'b0, 32'h0);
    chk("cfg reserved", pvp_pkg::CFG_WMASK, rdData);
  endtask

  task t_frame(input logic [31:0] cfg, input logic [31:0] jit, input int len,
               input int hiExp, input int clks, input int tol);
    int   bits;
    int   hi;
    int   d;
    logic prev;
    logic s;
    time  t0;
    apb(pvp_pkg::OFS_JIT, 1'b1, jit);
    apb(pvp_pkg::OFS_CFG, 1'b1, cfg);
    rise(1);
    rise(1);
    t0 = $time;
    bits = 1;
    hi = 1;
    prev = 1'b1;
    forever
    begin
      rise(0);
      s = pins.syncOut;
      if (s && !prev)
        break;
      bits++;
      hi += s;
      prev = s;
    end
    d = int'(($time - t0) / 100);
    if (d >= clks - tol && d <= clks + tol)
      d = clks;
    chk("frame bits", len, bits);
    chk("sync bits", hiExp, hi);
    chk("frame clocks", clks, d);
  endtask

  task t_suppress;
    int s;
    int h;
    apb(pvp_pkg::OFS_CFG, 1'b1, 32'h00000100);
    repeat (400) @(posedge clk);
    s = 0;
    h = 0;
    repeat (1216)
    begin
      @(posedge clk);
      s += pins.syncOut;
      h += pins.clkOut;
    end
    chk("sync suppressed", 0, s);
    chk("clock high time", 608, h);
  endtask

  task t_release(input logic [31:0] cfg, input logic e1, input logic e2);
    apb(pvp_pkg::OFS_CFG, 1'b1, cfg);
    rise(1);
    rise(1);
    repeat (16)
    begin
      waitPin(0, 1'b1);
      waitPin(0, 1'b0);
    end
    repeat (3) @(posedge clk);
    chk("oe after fall", e1, pins.dataOe);
    waitPin(0, 1'b1);
    repeat (3) @(posedge clk);
    chk("oe after rise", e2, pins.dataOe);
  endtask

  task t_tx(input int i);
    logic [15:0] w;
    int          n;
    n = (txCfg[i][28:27] == pvp_pkg::FMT_8_IN_8) ? 8 : 16;
    apb(pvp_pkg::OFS_CFG, 1'b1, txCfg[i]);
    rise(1);
    rise(1);
    w = 16'h0;
    repeat (n)
    begin
      waitPin(0, 1'b1);
      waitPin(0, 1'b0);
      w = {w[14:0], pins.dataOut};
    end
    chk("tx slot", txExp[i], w);
  endtask

  task t_slave(input logic [31:0] cfg, input logic sh, input logic [15:0] exp);
    logic [15:0] n0;
    apb(pvp_pkg::OFS_CFG, 1'b1, cfg);
    shortOn <= sh;
    slaveOn <= 1'b1;
    repeat (1000) @(posedge clk);
    chk("slave drivers", 32'h0, {pins.clkOe, pins.syncOe});
    apb(pvp_pkg::OFS_RX, 1'b0, 32'h0);
    chk("rx word", exp, rdData[15:0]);
    n0 = rdData[31:16];
    repeat (509) @(posedge clk);
    apb(pvp_pkg::OFS_RX, 1'b0, 32'h0);
    chk("rx count", n0 + 16'h2, rdData[31:16]);
    slaveOn <= 1'b0;
  endtask

  task results;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    paddr = 8'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    slaveOn = 1'b0;
    shortOn = 1'b0;
    badCount = 0;
    cmpCount = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_frame(32'h00200000, pvp_pkg::JIT_RESET, 16, 8, 1248, 0);
    t_frame(32'h00000000, pvp_pkg::JIT_RESET, 32, 8, 1216, 0);
    t_frame(32'h00400000, pvp_pkg::JIT_RESET, 64, 8, 1152, 0);
    t_frame(32'h00000004, pvp_pkg::JIT_RESET, 32, 1, 1216, 0);
    t_frame(32'h00001000, pvp_pkg::JIT_RESET, 32, 8, 1216, 0);
    t_frame(32'h00001800, pvp_pkg::JIT_RESET, 64, 16, 1250, 2);
    t_frame(32'h00000800, 32'h08100177, 64, 8, 625, 2);
    t_frame(32'h00001800, 32'h04080177, 32, 16, 625, 2);
    t_suppress();
    apb(pvp_pkg::OFS_TX, 1'b1, 32'h000512b4);
    for (int i = 0; i < 8; i++)
      t_tx(i);
    t_release(32'h08000000, 1'b1, 1'b1);
    t_release(32'h08000040, 1'b0, 1'b0);
    t_release(32'h080000c0, 1'b1, 1'b0);
    t_slave(32'h08000802, 1'b0, 16'hc35a);
    t_slave(32'h08000006, 1'b1, 16'hc35a);
    t_slave(32'h08000022, 1'b0, 16'h5ac3);
    results();
  end
endmodule
